// *** design/smbus_block_defs.vh ***
// smbus_block_defs.vh: offsets, field positions, reset values, engine op codes, check polynomial and timing counts of the block host
// assumes: included by bare name from the design files; nothing else is defined here
`ifndef SMBUS_BLOCK_DEFS_VH
`define SMBUS_BLOCK_DEFS_VH

// register offsets on the byte-wide i/o port
`define REG_HOST_STATUS 8'h00
`define REG_HOST_CONTROL 8'h02
`define REG_HOST_COMMAND 8'h03
`define REG_SLAVE_ADDR 8'h04
`define REG_DATA0 8'h05
`define REG_BLOCK_DATA 8'h07

// host status bit positions
`define ST_BUSY 0
`define ST_CMD_DONE 1
`define ST_DEV_ERR 2
`define ST_PEC_ERR 3
`define ST_BYTE_DONE 7

// host control bit positions
`define CTL_IRQ_EN 0
`define CTL_READ 1
`define CTL_PEC 2
`define CTL_TWO_WIRE 3
`define CTL_LAST_BYTE 5
`define CTL_START 6

// reset value of every byte register
`define RESET_BYTE 8'h00

// bit engine operations
`define OP_START 2'h0
`define OP_STOP 2'h1
`define OP_WRITE 2'h2
`define OP_READ 2'h3

// packet check polynomial x^8+x^2+x+1
`define PEC_POLY 8'h07

// timing: controller clock period in ns, link bit period in ns, quarter-bit count
`define MCLK_PERIOD_NS 40
`define LINK_PERIOD_NS 320
`define QUARTER_CYCLES (`LINK_PERIOD_NS / (4 * `MCLK_PERIOD_NS))

`endif

// *** design/link_bit_engine.v ***
// link_bit_engine: start, stop and byte-with-acknowledge sequencing on an open-drain two-wire link
// assumes: sda_sync is already synchronised to mclk; no clock stretching and no arbitration
`include "smbus_block_defs.vh"

module link_bit_engine #(
  parameter QUARTER = `QUARTER_CYCLES
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // operation request
  input wire go,
  input wire [1:0] op,
  input wire [7:0] tx_byte,
  input wire ack_level,
  // synchronised data line
  input wire sda_sync,
  // results
  output reg busy_q,
  output reg done_q,
  output reg [7:0] rx_q,
  output reg nack_q,
  // open-drain enables, low drives the line low
  output reg scl_oe_n_q,
  output reg sda_oe_n_q
);

  // full-width count first, then cut on purpose to the counter's width
  localparam integer QMAX_W = QUARTER - 1;
  localparam [7:0] QMAX = QMAX_W[7:0];

  reg [7:0] cnt_q;
  reg [1:0] op_q;
  reg [7:0] tx_q;
  reg ackl_q;
  reg [1:0] phase_q;
  reg [3:0] bit_q;
  wire tick;
  wire last_bit;
  wire bit_val;

  assign tick = (cnt_q == QMAX);
  assign last_bit = (bit_q == 4'h8);
  // ninth bit is the acknowledge slot: released on writes, ack_level on reads
  assign bit_val = last_bit ? ((op_q == `OP_WRITE) ? 1'b1 : ackl_q) : ((op_q == `OP_WRITE) ? tx_q[7] : 1'b1);

  // quarter-bit sequencer; scl is always left low after a byte so a pause stretches the clock
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      op_q <= `OP_START;
      tx_q <= 8'h00;
      ackl_q <= 1'b0;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        cnt_q <= 8'h00;
        if (go) begin
          busy_q <= 1'b1;
          op_q <= op;
          tx_q <= tx_byte;
          ackl_q <= ack_level;
          phase_q <= 2'h0;
          bit_q <= 4'h0;
        end
      end else begin
        cnt_q <= tick ? 8'h00 : cnt_q + 8'h01;
        if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (op_q)
            `OP_START: begin
              // works from an idle bus and as a repeated start from scl low
              if (phase_q == 2'h0) sda_oe_n_q <= 1'b1;
              if (phase_q == 2'h1) scl_oe_n_q <= 1'b1;
              if (phase_q == 2'h2) sda_oe_n_q <= 1'b0;
              if (phase_q == 2'h3) begin
                scl_oe_n_q <= 1'b0;
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
            `OP_STOP: begin
              if (phase_q == 2'h0) sda_oe_n_q <= 1'b0;
              if (phase_q == 2'h1) scl_oe_n_q <= 1'b1;
              if (phase_q == 2'h2) sda_oe_n_q <= 1'b1;
              if (phase_q == 2'h3) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
            default: begin
              if (phase_q == 2'h0) sda_oe_n_q <= bit_val;
              if (phase_q == 2'h1) scl_oe_n_q <= 1'b1;
              if (phase_q == 2'h2) begin
                if (last_bit) nack_q <= sda_sync;
                else rx_q <= {rx_q[6:0], sda_sync};
              end
              if (phase_q == 2'h3) begin
                scl_oe_n_q <= 1'b0;
                tx_q <= {tx_q[6:0], 1'b0};
                if (last_bit) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                end else begin
                  bit_q <= bit_q + 4'h1;
                end
              end
            end
          endcase
        end
      end
    end
  end

endmodule

// *** design/smbus_block_host.v ***
// smbus_block_host: block write and block read sequencer with a one-byte block data register
// assumes: byte-wide i/o register port on mclk, open-drain link lines resolved outside, no other master
//
// Behaviour
// - block write sends a byte count after address and command code.
// - block data passes through one byte register at offset 07h.
// - write sends address, command, data 0 count, then bytes from block data.
// - after each written byte set flag; next byte only once flag cleared.
// - read stores count in data 0, first byte in block data, flags and interrupts.
// - software sets last-byte bit after byte N-1; byte N gets not-acknowledge.
// - every block byte sets the flag and interrupts; no transfer until cleared.
// - clearing flag after final byte sets command complete: n+1 interrupts.
// - plain two-wire block write sends data 0 bytes but omits the count.
// - write frame: start, address, write, ack, command, ack, count, ack, data, stop.
// - read frame: command, repeated start, address read, count, host-acked data, last nacked.
// - packet checking on read acks byte N, receives check byte, nacks it, stops.
// - plain two-wire mode changes the command format for two-wire devices.
`include "smbus_block_defs.vh"

module smbus_block_host #(
  parameter QUARTER = `QUARTER_CYCLES
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // byte-wide i/o register port
  input wire [7:0] io_addr,
  input wire io_wr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_q,
  // link clock, open drain
  input wire scl_in,
  output reg scl_o_q,
  output wire scl_oe_n,
  // link data, open drain
  input wire sda_in,
  output reg sda_o_q,
  output wire sda_oe_n,
  // interrupt towards the system
  output reg system_mgmt_interrupt_q
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_START = 4'h1;
  localparam [3:0] S_ADDR_W = 4'h2;
  localparam [3:0] S_CMD = 4'h3;
  localparam [3:0] S_COUNT = 4'h4;
  localparam [3:0] S_WDATA = 4'h5;
  localparam [3:0] S_WAIT_BD = 4'h6;
  localparam [3:0] S_PEC_TX = 4'h7;
  localparam [3:0] S_RSTART = 4'h8;
  localparam [3:0] S_ADDR_R = 4'h9;
  localparam [3:0] S_RCOUNT = 4'ha;
  localparam [3:0] S_RDATA = 4'hb;
  localparam [3:0] S_PEC_RX = 4'hc;
  localparam [3:0] S_STOP = 4'hd;
  // software-visible state
  reg irq_en_q, read_q, packet_check_enable_q, two_wire_q, last_byte_q;
  reg [7:0] host_cmd_q, slave_addr_q, data0_q, block_data_byte_q;
  reg byte_complete_flag_q, command_complete_flag_q, dev_err_q, pec_err_q;
  // sequencer state
  reg [3:0] state_q;
  reg [7:0] remain_q;
  reg [7:0] pec_q;
  reg issued_q;
  reg sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q;
  // engine request
  reg [1:0] eng_op;
  reg [7:0] eng_tx;
  reg eng_ack;
  wire eng_go;
  wire eng_busy, eng_done, eng_nack;
  wire [7:0] eng_rx;
  wire ctl_wr, st_wr, start_req;
  // crc-8 over one byte, shared by the transmit and receive paths
  function [7:0] crc8;
    input [7:0] crc;
    input [7:0] data;
    integer i;
    reg [7:0] x;
    begin
      x = crc ^ data;
      for (i = 0; i < 8; i = i + 1) begin
        x = x[7] ? ({x[6:0], 1'b0} ^ `PEC_POLY) : {x[6:0], 1'b0};
      end
      crc8 = x;
    end
  endfunction

  // two-stage synchronisers; only the second stage is read
  always @(posedge mclk) begin
    if (!rst_n) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
    end
  end
  assign ctl_wr = io_wr && (io_addr == `REG_HOST_CONTROL);
  assign st_wr = io_wr && (io_addr == `REG_HOST_STATUS);
  // a start is refused while busy or while someone else holds a line low
  assign start_req = ctl_wr && io_wdata[`CTL_START] && (state_q == S_IDLE) && scl_s2_q && sda_s2_q;
  // what the current state asks of the bit engine
  always @* begin
    eng_op = `OP_WRITE;
    eng_tx = 8'h00;
    eng_ack = 1'b0;
    case (state_q)
      S_START, S_RSTART: eng_op = `OP_START;
      S_STOP: eng_op = `OP_STOP;
      S_ADDR_W: eng_tx = {slave_addr_q[7:1], 1'b0};
      S_CMD: eng_tx = host_cmd_q;
      S_COUNT: eng_tx = data0_q;
      S_WDATA: eng_tx = block_data_byte_q;
      S_PEC_TX: eng_tx = pec_q;
      S_ADDR_R: eng_tx = {slave_addr_q[7:1], 1'b1};
      S_RCOUNT: eng_op = `OP_READ;
      S_RDATA: begin
        eng_op = `OP_READ;
        // with packet checking the check byte takes the final not-acknowledge
        eng_ack = last_byte_q && !packet_check_enable_q;
      end
      S_PEC_RX: begin
        eng_op = `OP_READ;
        eng_ack = 1'b1;
      end
      default: eng_op = `OP_WRITE;
    endcase
  end
  // idle and the byte pause issue nothing, so scl stays low while paused
  assign eng_go = (state_q != S_IDLE) && (state_q != S_WAIT_BD) && !issued_q && !eng_busy;
  // registers and block sequencer; hardware sets are written last so a set beats a same-cycle clear
  always @(posedge mclk) begin
    if (!rst_n) begin
      irq_en_q <= 1'b0;
      read_q <= 1'b0;
      packet_check_enable_q <= 1'b0;
      two_wire_q <= 1'b0;
      last_byte_q <= 1'b0;
      host_cmd_q <= `RESET_BYTE;
      slave_addr_q <= `RESET_BYTE;
      data0_q <= `RESET_BYTE;
      block_data_byte_q <= `RESET_BYTE;
      byte_complete_flag_q <= 1'b0;
      command_complete_flag_q <= 1'b0;
      dev_err_q <= 1'b0;
      pec_err_q <= 1'b0;
      state_q <= S_IDLE;
      remain_q <= 8'h00;
      pec_q <= 8'h00;
      issued_q <= 1'b0;
    end else begin
      // software writes
      if (ctl_wr) begin
        irq_en_q <= io_wdata[`CTL_IRQ_EN];
        last_byte_q <= io_wdata[`CTL_LAST_BYTE];
        if (state_q == S_IDLE) begin
          read_q <= io_wdata[`CTL_READ];
          packet_check_enable_q <= io_wdata[`CTL_PEC];
          two_wire_q <= io_wdata[`CTL_TWO_WIRE];
        end
      end
      if (io_wr && (io_addr == `REG_HOST_COMMAND)) host_cmd_q <= io_wdata;
      if (io_wr && (io_addr == `REG_SLAVE_ADDR)) slave_addr_q <= io_wdata;
      if (io_wr && (io_addr == `REG_DATA0)) data0_q <= io_wdata;
      if (io_wr && (io_addr == `REG_BLOCK_DATA)) block_data_byte_q <= io_wdata;
      // write-one-to-clear status
      if (st_wr && io_wdata[`ST_BYTE_DONE]) byte_complete_flag_q <= 1'b0;
      if (st_wr && io_wdata[`ST_CMD_DONE]) command_complete_flag_q <= 1'b0;
      if (st_wr && io_wdata[`ST_DEV_ERR]) dev_err_q <= 1'b0;
      if (st_wr && io_wdata[`ST_PEC_ERR]) pec_err_q <= 1'b0;
      if (start_req) begin
        state_q <= S_START;
        remain_q <= data0_q;
        pec_q <= 8'h00;
        dev_err_q <= 1'b0;
        pec_err_q <= 1'b0;
        last_byte_q <= 1'b0; // mode bits come from the idle control write above
      end
      if (eng_go) issued_q <= 1'b1;
      // wait out the pause until software releases the flag
      if (state_q == S_WAIT_BD && !byte_complete_flag_q) begin
        if (remain_q != 8'h00) state_q <= read_q ? S_RDATA : S_WDATA;
        else if (packet_check_enable_q) state_q <= read_q ? S_PEC_RX : S_PEC_TX;
        else state_q <= S_STOP;
      end
      if (eng_done) begin
        issued_q <= 1'b0;
        if (eng_op == `OP_WRITE) pec_q <= crc8(pec_q, eng_tx);
        else if (eng_op == `OP_READ && state_q != S_PEC_RX) pec_q <= crc8(pec_q, eng_rx);
        // a missing slave acknowledge abandons the message with a stop
        if (eng_op == `OP_WRITE && eng_nack) begin
          dev_err_q <= 1'b1;
          state_q <= S_STOP;
        end else begin
          case (state_q)
            S_START: state_q <= S_ADDR_W;
            S_ADDR_W: state_q <= S_CMD;
            S_CMD: begin
              if (read_q) state_q <= S_RSTART;
              else if (two_wire_q) state_q <= S_WDATA;
              else state_q <= S_COUNT;
            end
            S_COUNT: state_q <= S_WDATA;
            S_WDATA: begin
              remain_q <= remain_q - 8'h01;
              byte_complete_flag_q <= 1'b1;
              state_q <= S_WAIT_BD;
            end
            S_PEC_TX: state_q <= S_STOP;
            S_RSTART: state_q <= S_ADDR_R;
            S_ADDR_R: state_q <= S_RCOUNT;
            S_RCOUNT: begin
              data0_q <= eng_rx;
              remain_q <= eng_rx;
              // a zero count cannot be walked; end the message as a device error
              if (eng_rx == 8'h00) begin
                dev_err_q <= 1'b1;
                state_q <= S_STOP;
              end else begin
                state_q <= S_RDATA;
              end
            end
            S_RDATA: begin
              block_data_byte_q <= eng_rx;
              remain_q <= remain_q - 8'h01;
              byte_complete_flag_q <= 1'b1;
              state_q <= S_WAIT_BD;
            end
            S_PEC_RX: begin
              if (eng_rx != pec_q) pec_err_q <= 1'b1;
              state_q <= S_STOP;
            end
            S_STOP: begin
              state_q <= S_IDLE;
              if (!dev_err_q) command_complete_flag_q <= 1'b1;
            end
            default: state_q <= S_IDLE;
          endcase
        end
      end
    end
  end

  // registered read data, interrupt and constant-low drive values
  always @(posedge mclk) begin
    if (!rst_n) begin
      io_rdata_q <= 8'h00;
      system_mgmt_interrupt_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      // one interrupt per byte and one more for completion or a device error
      system_mgmt_interrupt_q <= irq_en_q && (byte_complete_flag_q || command_complete_flag_q || dev_err_q);
      case (io_addr)
        `REG_HOST_STATUS: io_rdata_q <= {byte_complete_flag_q, 3'h0, pec_err_q, dev_err_q,
                                          command_complete_flag_q, (state_q != S_IDLE)};
        `REG_HOST_CONTROL: io_rdata_q <= {2'h0, last_byte_q, 1'b0, two_wire_q, packet_check_enable_q, read_q, irq_en_q};
        `REG_HOST_COMMAND: io_rdata_q <= host_cmd_q;
        `REG_SLAVE_ADDR: io_rdata_q <= slave_addr_q;
        `REG_DATA0: io_rdata_q <= data0_q;
        `REG_BLOCK_DATA: io_rdata_q <= block_data_byte_q;
        default: io_rdata_q <= 8'h00;
      endcase
    end
  end
  link_bit_engine #(
    .QUARTER(QUARTER)
  ) u_engine (
    .mclk(mclk),
    .rst_n(rst_n),
    .go(eng_go),
    .op(eng_op),
    .tx_byte(eng_tx),
    .ack_level(eng_ack),
    .sda_sync(sda_s2_q),
    .busy_q(eng_busy),
    .done_q(eng_done),
    .rx_q(eng_rx),
    .nack_q(eng_nack),
    .scl_oe_n_q(scl_oe_n),
    .sda_oe_n_q(sda_oe_n)
  );

endmodule

// *** sim/smbus_block_host_checker.sv ***
// smbus_block_host_checker: port-level link and register assertions for the block host
// assumes: one mclk domain, synchronous active-low reset; the clock-high figure holds for QUARTER of 2
module smbus_block_host_checker #(
  parameter QUARTER = 2
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // register port
  input wire [7:0] io_addr,
  input wire io_wr,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata_q,
  // link enables and interrupt
  input wire scl_o_q,
  input wire scl_oe_n,
  input wire sda_o_q,
  input wire sda_oe_n,
  input wire system_mgmt_interrupt_q
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QL = 2 * QUARTER;
  logic flag_q, en_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // byte-complete shadow learnt from status reads; a read right after a status write is stale, so skip it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      if (io_wr && io_addr == 8'h00 && io_wdata[7]) flag_q <= 1'b0;
      else if (!$past(io_wr) && $past(io_addr) == 8'h00 && io_rdata_q[7]) flag_q <= 1'b1;
      if (io_wr && io_addr == 8'h02) en_q <= io_wdata[0];
    end
  end
  a_lines_open_drain: assert property (!scl_o_q && !sda_o_q) else $error("link line driven high");
  a_reset_quiet: assert property (!$past(rst_n) |->
    scl_oe_n && sda_oe_n && !system_mgmt_interrupt_q && io_rdata_q == 8'h00) else $error("not idle after reset");
  a_pause_scl_low: assert property (flag_q |-> !scl_oe_n) else $error("clock released in pause");
  a_irq_needs_en: assert property (system_mgmt_interrupt_q |-> $past(en_q)) else $error("irq while off");
  a_irq_on_flag: assert property (flag_q && $past(en_q) |-> system_mgmt_interrupt_q) else $error("no irq");
  a_unmapped_zero: assert property ($past(io_addr) inside {8'h01, 8'h06, [8'h08:8'hff]} |->
    io_rdata_q == 8'h00) else $error("unmapped read not zero");
  a_clock_high_time: assert property ($rose(scl_oe_n) |-> scl_oe_n[*4]) else $error("short clock high");
  a_start_then_clock: assert property ($fell(sda_oe_n) && scl_oe_n |->
    !sda_oe_n throughout (##[1:QL] !scl_oe_n)) else $error("start not followed by clock low");
  c_pause: cover property ($rose(flag_q));
  c_irq: cover property ($rose(system_mgmt_interrupt_q));
  c_start: cover property ($fell(sda_oe_n) && scl_oe_n);
endmodule
bind smbus_block_host smbus_block_host_checker #(.QUARTER(QUARTER)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .scl_o_q(scl_o_q),
  .scl_oe_n(scl_oe_n), .sda_o_q(sda_o_q), .sda_oe_n(sda_oe_n), .system_mgmt_interrupt_q(system_mgmt_interrupt_q));

// *** sim/slave_model.sv ***
// slave_model: behavioural two-wire slave; logs bytes it receives and answers reads from tx_mem
// assumes: scl and sda are the resolved pulled-up lines; it never stretches the clock
module slave_model (
  // resolved link lines
  input wire scl,
  input wire sda,
  // high pulls sda low
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic [7:0] tx_mem [0:15];
  logic [7:0] got [$];
  logic [7:0] hack [$];
  logic [3:0] n;
  logic rd, first, active, nak, sending;
  int ti, nack_at;
  initial begin
    sda_low = 1'b0;
    active = 1'b0;
    nack_at = -1;
  end
  // start or repeated start; n wraps to bit 0 on the following clock fall
  always @(negedge sda) if (scl === 1'b1) begin
    n = 4'hf;
    first = 1'b1;
    active = 1'b1;
    rd = 1'b0;
    nak = 1'b0;
    sending = 1'b0;
    ti = 0;
  end
  // stop ends the frame
  always @(posedge sda) if (scl === 1'b1) active = 1'b0;
  // sample data bits, and the host's answer after a byte we sent
  always @(posedge scl) if (active) begin
    if (n < 4'h8) sh = {sh[6:0], sda};
    else if (sending) begin
      hack.push_back({7'h00, sda});
      nak = sda;
    end
  end
  // change sda only while scl is low, so no false start or stop is made
  always @(negedge scl) if (active) begin
    n = (n == 4'h8) ? 4'h0 : n + 4'h1;
    if (n == 4'h8 && !sending) begin
      if (first) rd = sh[0];
      sda_low = got.size() != nack_at;
      got.push_back(sh);
      first = 1'b0;
    end else if (n == 4'h8) begin
      sda_low = 1'b0;
      ti = ti + 1;
    end else begin
      if (n == 4'h0) sending = rd && !nak;
      sda_low = sending && !tx_mem[ti][4'h7 - n];
    end
  end
endmodule

// *** sim/testbench.sv ***
// testbench: register-level block write and block read runs of the block host against the slave model
// assumes: header on the include path; the checker binds itself to the host
`include "smbus_block_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, io_wr, irq_d;
  logic [7:0] io_addr, io_wdata, v;
  logic [7:0] exp_q [$];
  wire [7:0] io_rdata_q;
  wire scl_o_q, sda_o_q, scl_oe_n, sda_oe_n, sda_low, irq;
  int err_total, checks, irq_cnt;
  // pulled-up open-drain lines, low wins
  wire scl = scl_oe_n ? 1'b1 : scl_o_q;
  wire sda = (sda_oe_n ? 1'b1 : sda_o_q) & !sda_low;
  smbus_block_host #(.QUARTER(2)) u_dut (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .scl_in(scl), .scl_o_q(scl_o_q), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_o_q(sda_o_q), .sda_oe_n(sda_oe_n), .system_mgmt_interrupt_q(irq));
  slave_model u_slave (.scl(scl), .sda(sda), .sda_low(sda_low));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // count interrupt rising edges
  always @(posedge mclk) begin
    irq_d <= irq;
    if (irq === 1'b1 && irq_d === 1'b0) irq_cnt <= irq_cnt + 1;
  end
  task chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task wrap_up();
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // read data lands one edge after the address; sampled at the falling edge where it is settled
  task rd(input logic [7:0] a, output logic [7:0] d);
    io_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    d = io_rdata_q;
    @(posedge mclk);
  endtask
  task poll(input logic [7:0] m, output logic [7:0] s);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(8'h00, s);
      if ((s & m) === m) break;
    end
    if (i == 3000) begin
      err_total++;
      wrap_up();
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] q [$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[j]) for (int b = 7; b >= 0; b--) c = {c[6:0], 1'b0} ^ ((c[7] ^ q[j][b]) ? `PEC_POLY : 8'h00);
    return c;
  endfunction
  task do_write(input int n, input logic [7:0] ctl, input int nak);
    int i;
    exp_q = {8'h54, 8'hc3};
    if (!ctl[3]) exp_q.push_back(n[7:0]);
    if (nak >= 0) exp_q.push_back(8'h5a);
    u_slave.got = {};
    u_slave.nack_at = nak;
    irq_cnt = 0;
    wr(8'h04, 8'h54);
    wr(8'h03, 8'hc3);
    wr(8'h05, n[7:0]);
    wr(8'h07, 8'h5a);
    wr(8'h02, ctl);
    for (i = 0; i < n && nak < 0; i++) begin
      exp_q.push_back(8'h5a + i[7:0]);
      poll(8'h80, v);
      chk("pause status", v, 8'h81);
      repeat (40) @(posedge mclk);
      chk("pause scl", {7'h00, scl}, 8'h00);
      chk("pause irq", {7'h00, irq}, {7'h00, ctl[0]});
      chk("pause bytes", 8'(u_slave.got.size()), 8'(exp_q.size()));
      if (i < n - 1) wr(8'h07, 8'h5b + i[7:0]);
      wr(8'h00, 8'h80);
    end
    if (nak < 0 && ctl[2]) exp_q.push_back(crc(exp_q));
    poll(nak < 0 ? 8'h02 : 8'h04, v);
    repeat (40) @(posedge mclk);
    rd(8'h00, v);
    chk("end status", v & 8'h07, nak < 0 ? 8'h02 : 8'h04);
    chk("irq count", 8'(irq_cnt), ctl[0] ? 8'(n + 1) : 8'h00);
    chk("frame length", 8'(u_slave.got.size()), 8'(exp_q.size()));
    foreach (exp_q[k]) chk("frame byte", u_slave.got[k], exp_q[k]);
    wr(8'h00, 8'hff);
  endtask
  task do_read(input int n, input logic [7:0] ctl, input logic [7:0] bad);
    int i;
    u_slave.tx_mem[0] = n[7:0];
    for (i = 1; i <= n; i++) u_slave.tx_mem[i] = 8'hc0 + i[7:0];
    exp_q = {8'h54, 8'hc3, 8'h55};
    for (i = 0; i <= n; i++) exp_q.push_back(u_slave.tx_mem[i]);
    u_slave.tx_mem[n + 1] = crc(exp_q) ^ bad;
    u_slave.got = {};
    u_slave.hack = {};
    u_slave.nack_at = -1;
    wr(8'h04, 8'h55);
    wr(8'h03, 8'hc3);
    wr(8'h02, ctl);
    for (i = 1; i <= n; i++) begin
      poll(8'h80, v);
      if (i == 1) rd(8'h05, v);
      if (i == 1) chk("read count", v, n[7:0]);
      rd(8'h07, v);
      chk("read byte", v, 8'hc0 + i[7:0]);
      if (i == n - 1) wr(8'h02, (ctl & 8'h01) | 8'h20);
      wr(8'h00, 8'h80);
    end
    poll(8'h02, v);
    repeat (40) @(posedge mclk);
    rd(8'h00, v);
    chk("read end status", v, bad != 8'h00 ? 8'h0a : 8'h02);
    chk("ack count", 8'(u_slave.hack.size()), 8'(n + 1 + ctl[2]));
    foreach (u_slave.hack[k]) chk("host ack", u_slave.hack[k], 8'(k == u_slave.hack.size() - 1));
    chk("read frame length", 8'(u_slave.got.size()), 8'h03);
    foreach (u_slave.got[k]) chk("read frame byte", u_slave.got[k], exp_q[k]);
    wr(8'h00, 8'hff);
  endtask
  initial begin
    rst_n = 1'b0;
    io_wr = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    irq_d = 1'b0;
    err_total = 0;
    checks = 0;
    irq_cnt = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int a = 0; a < 8; a++) begin
      rd(a[7:0], v);
      chk("reset value", v, 8'h00);
    end
    wr(8'h07, 8'ha5);
    rd(8'h07, v);
    chk("block data", v, 8'ha5);
    wr(8'h06, 8'hff);
    rd(8'h06, v);
    chk("unmapped", v, 8'h00);
    do_write(3, 8'h41, -1);
    do_write(2, 8'h45, -1);
    do_write(2, 8'h49, -1);
    do_write(1, 8'h40, 3);
    do_read(3, 8'h43, 8'h00);
    do_read(2, 8'h47, 8'h00);
    do_read(2, 8'h47, 8'h01);
    wrap_up();
  end
endmodule
